// file: hdl/aux_vol_pkg.sv
// Package: register map, field layout, reset values and timing for the volume/filter bank
package aux_vol_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_REC_LEFT_VOL   = 12'h500;
  localparam logic [11:0] OFS_REC_RIGHT_VOL  = 12'h501;
  localparam logic [11:0] OFS_PLAY_LEFT_VOL  = 12'h502;
  localparam logic [11:0] OFS_PLAY_RIGHT_VOL = 12'h503;
  localparam logic [11:0] OFS_REC_FILTER     = 12'h510;
  localparam logic [11:0] OFS_PLAY_FILTER    = 12'h520;
  localparam logic [11:0] OFS_APPLIED_VOL    = 12'h5F0;
  localparam logic [11:0] OFS_PLAY_STATUS    = 12'h5F1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VU_BIT        = 8;
  localparam int GAIN_MSB      = 7;
  localparam int HPF_CUT_MSB   = 14;
  localparam int HPF_CUT_LSB   = 13;
  localparam int HPF_LEFT_BIT  = 12;
  localparam int HPF_RIGHT_BIT = 11;
  localparam int MUTE_BIT      = 9;
  localparam int MONO_BIT      = 7;
  localparam int RATE_BIT      = 5;
  localparam int UNMUTE_RAMP_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values and gain codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  GAIN_RESET      = 8'hC0;
  localparam logic [7:0]  GAIN_MUTE_CODE  = 8'h00;
  localparam logic [7:0]  REC_GAIN_TOP    = 8'hEF;
  localparam logic [7:0]  PLAY_UNITY_CODE = 8'hC0;
  localparam logic [1:0]  HPF_CUT_RESET   = 2'h0;
  localparam logic        MUTE_RESET      = 1'b1;

  // ----------------------------------------------------------------
  // Ramp timing in samples per gain step
  // ----------------------------------------------------------------
  localparam int FAST_RAMP_SAMPLES = 2;
  localparam int SLOW_RAMP_SAMPLES = 32;

  typedef enum logic [1:0] {
    HPF_HIFI   = 2'b00,
    HPF_VOICE1 = 2'b01,
    HPF_VOICE2 = 2'b10,
    HPF_VOICE3 = 2'b11
  } hpf_cut_e;

  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
  } gain_pair_s;

  typedef struct packed {
    hpf_cut_e cutoff;
    logic     left_en;
    logic     right_en;
  } record_filter_s;

endpackage

// file: hdl/vol_pair_latch.sv
// Pending/applied gain pair with simultaneous update on a trigger
`timescale 1ns/1ns
module vol_pair_latch #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_wr_left,
  input  wire logic             i_wr_right,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_update,
  output logic      [WIDTH-1:0] o_pend_left,
  output logic      [WIDTH-1:0] o_pend_right,
  output logic      [WIDTH-1:0] o_app_left,
  output logic      [WIDTH-1:0] o_app_right
);
  import aux_vol_pkg::*;

  if (WIDTH != 8) begin : g_width_check
    $error("vol_pair_latch: WIDTH must be 8");
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pend_left  <= GAIN_RESET;
      o_pend_right <= GAIN_RESET;
    end else begin
      if (i_wr_left) begin
        o_pend_left <= i_wdata;
      end
      if (i_wr_right) begin
        o_pend_right <= i_wdata;
      end
    end
  end

  // Both halves move on one edge; a write carrying the trigger applies its own new value
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_app_left  <= GAIN_RESET;
      o_app_right <= GAIN_RESET;
    end else if (i_update) begin
      o_app_left  <= i_wr_left  ? i_wdata : o_pend_left;
      o_app_right <= i_wr_right ? i_wdata : o_pend_right;
    end
  end
endmodule

// file: hdl/mute_ramp.sv
// Soft mute gain ramp for one playback channel, stepping one code per i_step ramp tick
`timescale 1ns/1ns
module mute_ramp (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_step,
  input  wire logic       i_mute,
  input  wire logic       i_ramp_unmute,
  input  wire logic [7:0] i_target,
  output logic      [7:0] o_gain
);
  import aux_vol_pkg::*;

  logic [7:0] cap;
  assign cap = (i_target > PLAY_UNITY_CODE) ? PLAY_UNITY_CODE : i_target;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_gain <= GAIN_MUTE_CODE;
    end else if (i_mute) begin
      if (i_step && o_gain != GAIN_MUTE_CODE) begin
        o_gain <= o_gain - 8'h01;
      end
    end else if (!i_ramp_unmute) begin
      o_gain <= cap;
    end else if (o_gain > cap) begin
      o_gain <= cap;
    end else if (i_step && o_gain < cap) begin
      o_gain <= o_gain + 8'h01;
    end
  end
endmodule

// file: hdl/aux_iface_volume_filter_regs.sv
// Register bank for the second audio interface record/playback volume and filter controls
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module aux_iface_volume_filter_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_resetn,
  input  wire logic [ADDR_W-1:0]           i_addr,
  input  wire logic [15:0]                 i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire logic                        i_play_sample,
  output logic      [15:0]                 o_rdata,
  output aux_vol_pkg::gain_pair_s          o_record_gain,
  output aux_vol_pkg::gain_pair_s          o_playback_gain,
  output aux_vol_pkg::record_filter_s      o_record_filter,
  output logic                             o_playback_mono_mix,
  output logic                             o_playback_muted
);
  import aux_vol_pkg::*;

  // The map decodes full 12-bit offsets; a narrower width would alias registers
  if (ADDR_W != 12) begin : g_addr_w_check
    $error("aux_iface_volume_filter_regs: ADDR_W must be 12");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_rl;
  logic wr_rr;
  logic wr_pl;
  logic wr_pr;
  logic wr_rf;
  logic wr_pf;
  logic rec_update;
  logic play_update;

  assign wr_rl = i_wr && (i_addr == OFS_REC_LEFT_VOL);
  assign wr_rr = i_wr && (i_addr == OFS_REC_RIGHT_VOL);
  assign wr_pl = i_wr && (i_addr == OFS_PLAY_LEFT_VOL);
  assign wr_pr = i_wr && (i_addr == OFS_PLAY_RIGHT_VOL);
  assign wr_rf = i_wr && (i_addr == OFS_REC_FILTER);
  assign wr_pf = i_wr && (i_addr == OFS_PLAY_FILTER);

  assign rec_update  = (wr_rl || wr_rr) && i_wdata[VU_BIT];
  assign play_update = (wr_pl || wr_pr) && i_wdata[VU_BIT];

  // ----------------------------------------------------------------
  // Volume pairs
  // ----------------------------------------------------------------
  logic [7:0] rec_pend_l;
  logic [7:0] rec_pend_r;
  logic [7:0] rec_app_l;
  logic [7:0] rec_app_r;
  logic [7:0] play_pend_l;
  logic [7:0] play_pend_r;
  logic [7:0] play_app_l;
  logic [7:0] play_app_r;

  // Pending values are held apart from applied ones
  vol_pair_latch #(.WIDTH(8)) u_rec_pair (
    .i_core_clk   (i_core_clk),
    .i_resetn     (i_resetn),
    .i_wr_left    (wr_rl),
    .i_wr_right   (wr_rr),
    .i_wdata      (i_wdata[GAIN_MSB:0]),
    .i_update     (rec_update),
    .o_pend_left  (rec_pend_l),
    .o_pend_right (rec_pend_r),
    .o_app_left   (rec_app_l),
    .o_app_right  (rec_app_r)
  );

  vol_pair_latch #(.WIDTH(8)) u_play_pair (
    .i_core_clk   (i_core_clk),
    .i_resetn     (i_resetn),
    .i_wr_left    (wr_pl),
    .i_wr_right   (wr_pr),
    .i_wdata      (i_wdata[GAIN_MSB:0]),
    .i_update     (play_update),
    .o_pend_left  (play_pend_l),
    .o_pend_right (play_pend_r),
    .o_app_left   (play_app_l),
    .o_app_right  (play_app_r)
  );

  // ----------------------------------------------------------------
  // Filter control registers
  // ----------------------------------------------------------------
  hpf_cut_e hpf_cut_r;
  logic     hpf_left_r;
  logic     hpf_right_r;
  logic     mute_r;
  logic     mono_r;
  logic     rate_r;
  logic     unmute_ramp_r;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hpf_cut_r <= hpf_cut_e'(HPF_CUT_RESET);
    end else if (wr_rf) begin
      hpf_cut_r <= hpf_cut_e'(i_wdata[HPF_CUT_MSB:HPF_CUT_LSB]);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hpf_left_r <= 1'b0;
    end else if (wr_rf) begin
      hpf_left_r <= i_wdata[HPF_LEFT_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hpf_right_r <= 1'b0;
    end else if (wr_rf) begin
      hpf_right_r <= i_wdata[HPF_RIGHT_BIT];
    end
  end

  // Playback comes up muted so nothing is heard before software sets the gains
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mute_r <= MUTE_RESET;
    end else if (wr_pf) begin
      mute_r <= i_wdata[MUTE_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mono_r <= 1'b0;
    end else if (wr_pf) begin
      mono_r <= i_wdata[MONO_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_r <= 1'b0;
    end else if (wr_pf) begin
      rate_r <= i_wdata[RATE_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unmute_ramp_r <= 1'b0;
    end else if (wr_pf) begin
      unmute_ramp_r <= i_wdata[UNMUTE_RAMP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Soft mute ramp; tick counted in samples so ramp time tracks fs
  // ----------------------------------------------------------------
  logic [4:0] samp_cnt_r;
  logic [4:0] samp_limit;
  logic       ramp_step;

  assign samp_limit = rate_r ? 5'(SLOW_RAMP_SAMPLES - 1) : 5'(FAST_RAMP_SAMPLES - 1);
  assign ramp_step  = i_play_sample && (samp_cnt_r >= samp_limit);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      samp_cnt_r <= 5'h00;
    end else if (i_play_sample) begin
      samp_cnt_r <= ramp_step ? 5'h00 : samp_cnt_r + 5'h01;
    end
  end

  logic [7:0]      ramp_l;
  logic [7:0]      ramp_r;
  logic [1:0][7:0] play_target;
  logic [1:0][7:0] ramp_gain;

  // Index 1 is the left channel and index 0 the right, as in the gain struct
  assign play_target = {play_app_l, play_app_r};

  // Gains above C0h saturate at unity inside the ramp
  // One shared tick keeps both channels in lockstep while ramping
  for (genvar ch = 0; ch < 2; ch++) begin : g_ramp
    mute_ramp u_ramp (
      .i_core_clk    (i_core_clk),
      .i_resetn      (i_resetn),
      .i_step        (ramp_step),
      .i_mute        (mute_r),
      .i_ramp_unmute (unmute_ramp_r),
      .i_target      (play_target[ch]),
      .o_gain        (ramp_gain[ch])
    );
  end

  assign ramp_l = ramp_gain[1];
  assign ramp_r = ramp_gain[0];

  // ----------------------------------------------------------------
  // Datapath-facing outputs, all registered
  // ----------------------------------------------------------------
  logic [7:0] rec_cap_l;
  logic [7:0] rec_cap_r;

  // Codes above EFh are clamped to the top step
  assign rec_cap_l = (rec_app_l > REC_GAIN_TOP) ? REC_GAIN_TOP : rec_app_l;
  assign rec_cap_r = (rec_app_r > REC_GAIN_TOP) ? REC_GAIN_TOP : rec_app_r;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_record_gain <= '{left: GAIN_RESET, right: GAIN_RESET};
    end else begin
      o_record_gain <= '{left: rec_cap_l, right: rec_cap_r};
    end
  end

  // Playback starts at the mute code, the same state the ramps reset into
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_playback_gain <= '{left: GAIN_MUTE_CODE, right: GAIN_MUTE_CODE};
    end else begin
      o_playback_gain <= '{left: ramp_l, right: ramp_r};
    end
  end

  // Cut-off code is sample-relative, so fc follows the record rate
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_record_filter <= '{cutoff: HPF_HIFI, left_en: 1'b0, right_en: 1'b0};
    end else begin
      o_record_filter <= '{cutoff: hpf_cut_r, left_en: hpf_left_r, right_en: hpf_right_r};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_playback_mono_mix <= 1'b0;
    end else begin
      o_playback_mono_mix <= mono_r;
    end
  end

  // Muted is reported only once both ramps have reached the mute code
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_playback_muted <= 1'b1;
    end else begin
      o_playback_muted <= mute_r && (ramp_l == GAIN_MUTE_CODE) && (ramp_r == GAIN_MUTE_CODE);
    end
  end

  // ----------------------------------------------------------------
  // Read port; update bits always read zero
  // ----------------------------------------------------------------
  logic [15:0] rd_nxt;

  always_comb begin
    rd_nxt = 16'h0000;
    unique case (i_addr)
      OFS_REC_LEFT_VOL:   rd_nxt[GAIN_MSB:0] = rec_pend_l;
      OFS_REC_RIGHT_VOL:  rd_nxt[GAIN_MSB:0] = rec_pend_r;
      OFS_PLAY_LEFT_VOL:  rd_nxt[GAIN_MSB:0] = play_pend_l;
      OFS_PLAY_RIGHT_VOL: rd_nxt[GAIN_MSB:0] = play_pend_r;
      OFS_REC_FILTER: begin
        rd_nxt[HPF_CUT_MSB:HPF_CUT_LSB] = hpf_cut_r;
        rd_nxt[HPF_LEFT_BIT]            = hpf_left_r;
        rd_nxt[HPF_RIGHT_BIT]           = hpf_right_r;
      end
      OFS_PLAY_FILTER: begin
        rd_nxt[MUTE_BIT]        = mute_r;
        rd_nxt[MONO_BIT]        = mono_r;
        rd_nxt[RATE_BIT]        = rate_r;
        rd_nxt[UNMUTE_RAMP_BIT] = unmute_ramp_r;
      end
      OFS_APPLIED_VOL:    rd_nxt = {ramp_l, ramp_r};
      OFS_PLAY_STATUS:    rd_nxt = {rec_app_l, rec_app_r};
      default:            rd_nxt = 16'h0000;
    endcase
  end

  // Idle zero keeps the read data quiet between reads
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rd_nxt;
    end else begin
      o_rdata <= 16'h0000;
    end
  end
endmodule

// file: dv/aux_vol_asserts.sv
// Checker: port-level properties of the volume and filter register bank
`timescale 1ns/1ns
module aux_vol_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic                        i_core_clk,
  input wire logic                        i_resetn,
  input wire logic [ADDR_W-1:0]           i_addr,
  input wire logic [15:0]                 i_wdata,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic                        i_play_sample,
  input wire logic [15:0]                 o_rdata,
  input wire aux_vol_pkg::gain_pair_s     o_record_gain,
  input wire aux_vol_pkg::gain_pair_s     o_playback_gain,
  input wire aux_vol_pkg::record_filter_s o_record_filter,
  input wire logic                        o_playback_mono_mix,
  input wire logic                        o_playback_muted
);
  import aux_vol_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire logic rec_vu = i_wr && i_wdata[VU_BIT] &&
                      (i_addr == OFS_REC_LEFT_VOL || i_addr == OFS_REC_RIGHT_VOL);
  wire logic rd_vol = i_rd && i_addr >= OFS_REC_LEFT_VOL && i_addr <= OFS_PLAY_RIGHT_VOL;
  sequence s_rec_left_update;
    rec_vu && i_addr == OFS_REC_LEFT_VOL;
  endsequence
  sequence s_filter_write;
    i_wr && i_addr == OFS_REC_FILTER;
  endsequence
  function automatic logic [7:0] top_clamp(input logic [7:0] v);
    return (v > REC_GAIN_TOP) ? REC_GAIN_TOP : v;
  endfunction
  // Write edge, one edge into the internal register, one more onto the port
  property p_rec_apply;
    s_rec_left_update |-> ##2 o_record_gain.left == top_clamp($past(i_wdata[7:0], 2));
  endproperty
  property p_filter_copy;
    s_filter_write |-> ##2 o_record_filter == $past(i_wdata[14:11], 2);
  endproperty
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  chk_update_reads_zero: assert property ($past(rd_vol) |-> o_rdata[VU_BIT] == 1'b0)
    else $error("volume update bit read back as one");
  chk_rec_gain_cap: assert property (o_record_gain.left <= REC_GAIN_TOP &&
                                     o_record_gain.right <= REC_GAIN_TOP)
    else $error("record gain above top code");
  chk_play_gain_cap: assert property (o_playback_gain.left <= PLAY_UNITY_CODE &&
                                      o_playback_gain.right <= PLAY_UNITY_CODE)
    else $error("playback gain above unity");
  chk_rec_pair_sync: assert property ($changed(o_record_gain) |->
                                      $past(rec_vu, 1) || $past(rec_vu, 2) || $past(rec_vu, 3))
    else $error("record gain moved without update write");
  chk_rec_apply_value: assert property (p_rec_apply)
    else $error("record left gain not applied");
  chk_filter_copy: assert property (p_filter_copy)
    else $error("record filter fields not copied");
  chk_mono_copy: assert property (i_wr && i_addr == OFS_PLAY_FILTER |->
                                  ##2 o_playback_mono_mix == $past(i_wdata[MONO_BIT], 2))
    else $error("mono mix not following write");
  chk_muted_gain_zero: assert property (o_playback_muted |-> o_playback_gain == 16'h0000)
    else $error("muted flag with nonzero gain");
endmodule

// file: dv/tb_top.sv
// Testbench: self-checking bench for the volume and filter register bank
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import aux_vol_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic           i_core_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_play_sample = 0;
  logic [11:0]    i_addr = 12'h000;
  logic [15:0]    i_wdata = 16'h0000, o_rdata, d;
  gain_pair_s     o_record_gain, o_playback_gain;
  record_filter_s o_record_filter;
  logic           o_playback_mono_mix, o_playback_muted;
  logic [7:0]     pend_l, pend_r, app_l, app_r;
  int             num_errors = 0, cmp_count = 0, cycles = 0, n;
  aux_iface_volume_filter_regs i_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_play_sample(i_play_sample), .o_rdata(o_rdata), .o_record_gain(o_record_gain),
    .o_playback_gain(o_playback_gain), .o_record_filter(o_record_filter),
    .o_playback_mono_mix(o_playback_mono_mix), .o_playback_muted(o_playback_muted));
  always #10 i_core_clk = ~i_core_clk;
  // ----------------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] rec_clamp(logic [7:0] v);
    return (v > 8'hEF) ? 8'hEF : v;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge i_core_clk) begin i_addr <= a; i_wdata <= v; i_wr <= 1'b1; end
    @(posedge i_core_clk) i_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge i_core_clk) begin i_addr <= a; i_rd <= 1'b1; end
    @(posedge i_core_clk) i_rd <= 1'b0;
    #1 `CHK(o_rdata, exp)
  endtask
  task automatic settle();
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge i_core_clk) i_play_sample <= 1'b1;
      @(posedge i_core_clk) i_play_sample <= 1'b0;
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Ceiling well above the several hundred cycles the sequence needs
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(12));
    repeat (12) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    for (int r = 0; r < 4; r++) chk_rd(OFS_REC_LEFT_VOL + 12'(r), 16'h00C0);
    chk_rd(OFS_REC_FILTER, 16'h0000);
    chk_rd(OFS_PLAY_FILTER, 16'h0200);
    `CHK({o_playback_muted, o_playback_gain}, 17'h10000)
    wr(12'h5FF, 16'hFFFF);
    chk_rd(12'h5FF, 16'h0000);
    wr(OFS_REC_LEFT_VOL, 16'h0010);
    settle();
    `CHK(o_record_gain, 16'hC0C0)
    chk_rd(OFS_REC_LEFT_VOL, 16'h0010);
    wr(OFS_REC_RIGHT_VOL, 16'h0120);
    settle();
    `CHK(o_record_gain, 16'h1020)
    wr(OFS_REC_LEFT_VOL, 16'h01F5);
    wr(OFS_REC_RIGHT_VOL, 16'h0000);
    settle();
    `CHK(o_record_gain, 16'hEF20)
    {pend_l, pend_r, app_l, app_r} = 32'hF500F520;
    // Random record traffic against a pending/applied model
    for (int k = 0; k < 24; k++) begin
      d = {7'h00, 1'($urandom()), 8'($urandom())};
      n = $urandom() % 2;
      wr(n ? OFS_REC_RIGHT_VOL : OFS_REC_LEFT_VOL, d);
      if (n) pend_r = d[7:0];
      else pend_l = d[7:0];
      if (d[8]) {app_l, app_r} = {pend_l, pend_r};
      settle();
      `CHK(o_record_gain, {rec_clamp(app_l), rec_clamp(app_r)})
      chk_rd(n ? OFS_REC_RIGHT_VOL : OFS_REC_LEFT_VOL, {8'h00, d[7:0]});
    end
    for (int c = 0; c < 4; c++) begin
      d = {1'b0, 2'(c), 2'($urandom()), 11'h000};
      wr(OFS_REC_FILTER, d);
      settle();
      `CHK(o_record_filter, d[14:11])
      chk_rd(OFS_REC_FILTER, d);
    end
    wr(OFS_PLAY_FILTER, 16'h0000);
    settle();
    `CHK({o_playback_muted, o_playback_gain}, 17'h0C0C0)
    wr(OFS_PLAY_LEFT_VOL, 16'h0030);
    settle();
    `CHK(o_playback_gain, 16'hC0C0)
    wr(OFS_PLAY_RIGHT_VOL, 16'h01FF);
    settle();
    `CHK(o_playback_gain, 16'h30C0)
    wr(OFS_PLAY_LEFT_VOL, 16'h0004);
    wr(OFS_PLAY_RIGHT_VOL, 16'h0103);
    settle();
    `CHK(o_playback_gain, 16'h0403)
    // Fast ramp: four steps down, two samples each, phase unknown
    wr(OFS_PLAY_FILTER, 16'h0200);
    n = 0;
    while (o_playback_muted !== 1'b1 && n < 100) begin
      pulse(1);
      settle();
      n++;
    end
    `CHK(n >= 7 && n <= 8, 1'b1)
    wr(OFS_PLAY_FILTER, 16'h0030);
    settle();
    `CHK(o_playback_gain, 16'h0000)
    pulse(64);
    settle();
    `CHK(o_playback_gain.left inside {8'h01, 8'h02}, 1'b1)
    pulse(104);
    settle();
    `CHK(o_playback_gain, 16'h0403)
    wr(OFS_PLAY_FILTER, 16'h0080);
    settle();
    `CHK(o_playback_mono_mix, 1'b1)
    chk_rd(OFS_PLAY_FILTER, 16'h0080);
    wr(OFS_APPLIED_VOL, 16'hFFFF);
    chk_rd(OFS_APPLIED_VOL, 16'h0403);
    chk_rd(OFS_PLAY_STATUS, {app_l, app_r});
    give_verdict();
  end
endmodule
bind aux_iface_volume_filter_regs aux_vol_asserts #(.ADDR_W(ADDR_W)) i_chk (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_play_sample(i_play_sample), .o_rdata(o_rdata),
  .o_record_gain(o_record_gain), .o_playback_gain(o_playback_gain),
  .o_record_filter(o_record_filter), .o_playback_mono_mix(o_playback_mono_mix),
  .o_playback_muted(o_playback_muted));
